/* File: bench/axi_output_id_mapper_tb_top.sv */
// self-checking bench for the output id mapper in shared and separate half-clock builds
`timescale 1ns/10ps
module axi_output_id_mapper_tb_top;
	logic clk, rst_n, stall, gate_byp, div_byp;
	logic fwd_valid, barrier_valid, walk_valid, dvm_valid;
	logic [3:0] fwd_id;
	logic [14:0] fwd_tag;
	logic [2:0] walk_queue;
	logic fwd_ready, barrier_ready, walk_ready, dvm_ready;
	logic main_m_valid, main_m_ready, ctl_m_valid, core_tick, clk_gate_open;
	logic [4:0] main_m_id, last_id;
	logic [14:0] main_m_tag;
	logic [3:0] ctl_m_id;
	// second build: separate control port, half-rate core
	logic h_walk_valid, h_dvm_valid, h_div_byp, h_walk_ready, h_dvm_ready;
	logic h_ctl_m_valid, h_core_tick;
	logic [3:0] h_ctl_m_id;
	int beats, fail_count, check_count, cycles;

	axi_output_id_mapper i_dut (
		.clk(clk), .rst_n(rst_n),
		.fwd_valid(fwd_valid), .fwd_id(fwd_id), .fwd_tag(fwd_tag), .fwd_ready(fwd_ready),
		.barrier_valid(barrier_valid), .barrier_ready(barrier_ready),
		.walk_valid(walk_valid), .walk_queue(walk_queue), .walk_ready(walk_ready),
		.dvm_valid(dvm_valid), .dvm_ready(dvm_ready),
		.test_gate_bypass(gate_byp), .test_div_bypass(div_byp),
		.main_m_valid(main_m_valid), .main_m_id(main_m_id), .main_m_tag(main_m_tag), .main_m_ready(main_m_ready),
		.ctl_m_valid(ctl_m_valid), .ctl_m_id(ctl_m_id), .ctl_m_ready(1'b1),
		.core_tick(core_tick), .clk_gate_open(clk_gate_open)
	);

	axi_output_id_mapper #(.SHARED_PORT(1'b0), .HALF_CLOCK(1'b1)) i_dut_half (
		.clk(clk), .rst_n(rst_n),
		.fwd_valid(1'b0), .fwd_id(4'h0), .fwd_tag(15'h0000), .fwd_ready(),
		.barrier_valid(1'b0), .barrier_ready(),
		.walk_valid(h_walk_valid), .walk_queue(walk_queue), .walk_ready(h_walk_ready),
		.dvm_valid(h_dvm_valid), .dvm_ready(h_dvm_ready),
		.test_gate_bypass(gate_byp), .test_div_bypass(h_div_byp),
		.main_m_valid(), .main_m_id(), .main_m_tag(), .main_m_ready(1'b1),
		.ctl_m_valid(h_ctl_m_valid), .ctl_m_id(h_ctl_m_id), .ctl_m_ready(1'b1),
		.core_tick(h_core_tick), .clk_gate_open()
	);

	axi_sink_model #(.ID_W(5)) i_sink (
		.clk(clk), .rst_n(rst_n), .valid(main_m_valid), .id(main_m_id), .stall(stall),
		.ready(main_m_ready), .last_id(last_id), .beats(beats)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic set_valid(input int src, input logic v);
		case (src)
			0: fwd_valid = v;
			1: barrier_valid = v;
			2: walk_valid = v;
			default: dvm_valid = v;
		endcase
	endtask

	function automatic logic ready_of(input int src);
		return (src == 0) ? fwd_ready : (src == 1) ? barrier_ready : (src == 2) ? walk_ready : dvm_ready;
	endfunction

	// one request, held until accepted, then the beat is judged while it stands
	task automatic issue(input int src, input logic [4:0] exp_id, input logic [14:0] exp_tag);
		int n;
		n = 0;
		@(negedge clk);
		set_valid(src, 1'b1);
		#1;
		while (ready_of(src) !== 1'b1 && n < 20) begin
			@(negedge clk);
			#1;
			n++;
		end
		@(negedge clk);
		set_valid(src, 1'b0);
		check_bit(main_m_valid, 1'b1, "beat valid");
		check_vec(main_m_id, exp_id, "beat id");
		check_vec(main_m_tag, exp_tag, "beat tag");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_widths();
		check_vec($bits(i_dut.main_m_id), 5, "shared width");
		check_vec($bits(i_dut.ctl_m_id), 4, "control width");
		check_vec($bits(i_dut.fwd_tag), 15, "tag width");
		check_vec($bits(i_dut_half.main_m_id), 5, "separate buffer width");
		check_vec($bits(i_dut_half.ctl_m_id), 4, "separate control width");
	endtask

	task automatic t_ids();
		fwd_id = 4'hA;
		fwd_tag = 15'h5A5A;
		issue(0, 5'h0A, 15'h5A5A);
		issue(1, 5'h1F, 15'h0000);
		for (int q = 0; q < 8; q++) begin
			walk_queue = 3'(q);
			issue(2, {2'h2, 3'(q)}, 15'h0000);
		end
		issue(3, 5'h18, 15'h0000);
	endtask

	// beat held by back pressure must stand and block the next request
	task automatic t_stall();
		// let the standing dvm beat drain before back pressure starts
		@(negedge clk);
		stall = 1'b1;
		fwd_id = 4'h3;
		issue(0, 5'h03, 15'h5A5A);
		barrier_valid = 1'b1;
		repeat (3) begin
			@(negedge clk);
			check_bit(barrier_ready, 1'b0, "blocked while stalled");
			check_vec(main_m_id, 5'h03, "beat stands");
		end
		barrier_valid = 1'b0;
		stall = 1'b0;
		issue(1, 5'h1F, 15'h0000);
	endtask

	task automatic t_prio();
		walk_queue = 3'h6;
		@(negedge clk);
		fwd_valid = 1'b1;
		walk_valid = 1'b1;
		#1;
		check_bit(walk_ready, 1'b1, "walk taken first");
		check_bit(fwd_ready, 1'b0, "fwd held off");
		@(negedge clk);
		fwd_valid = 1'b0;
		walk_valid = 1'b0;
		check_vec(main_m_id, 5'h16, "walk id");
		check_bit(ctl_m_valid, 1'b0, "separate port idle when shared");
		check_vec(ctl_m_id, 4'h0, "separate port id idle");
	endtask

	task automatic t_clocks();
		check_bit(core_tick, 1'b1, "full rate tick");
		gate_byp = 1'b1;
		div_byp = 1'b1;
		repeat (4) @(negedge clk);
		check_bit(clk_gate_open, 1'b1, "gate bypass");
		check_bit(core_tick, 1'b1, "divider bypass");
		gate_byp = 1'b0;
		div_byp = 1'b0;
		repeat (4) @(negedge clk);
		check_bit(clk_gate_open, 1'b0, "gate closed when idle");
		check_vec(beats, 14, "beats accepted downstream");
		check_vec(last_id, 5'h16, "last beat id downstream");
	endtask

	// half-rate core: requests wait for a tick, bypass restores full rate
	task automatic t_half();
		logic prev;
		walk_queue = 3'h5;
		@(negedge clk);
		while (h_core_tick !== 1'b0) @(negedge clk);
		h_walk_valid = 1'b1;
		#1;
		check_bit(h_walk_ready, 1'b0, "walk refused off tick");
		@(negedge clk);
		check_bit(h_walk_ready, 1'b1, "walk taken on tick");
		@(negedge clk);
		h_walk_valid = 1'b0;
		h_dvm_valid = 1'b1;
		check_bit(h_ctl_m_valid, 1'b1, "separate walk beat");
		check_vec(h_ctl_m_id, 4'h5, "separate walk id");
		check_bit(h_core_tick, 1'b0, "tick skipped");
		@(negedge clk);
		check_bit(h_dvm_ready, 1'b1, "dvm taken on tick");
		@(negedge clk);
		h_dvm_valid = 1'b0;
		check_vec(h_ctl_m_id, 4'h8, "separate dvm id");
		h_div_byp = 1'b1;
		repeat (4) @(negedge clk);
		check_bit(h_core_tick, 1'b1, "divider bypassed");
		@(negedge clk);
		check_bit(h_core_tick, 1'b1, "bypass holds full rate");
		h_div_byp = 1'b0;
		repeat (4) @(negedge clk);
		prev = h_core_tick;
		@(negedge clk);
		check_bit(h_core_tick, !prev, "half rate resumes");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// generous ceiling, the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		{rst_n, stall, gate_byp, div_byp} = 4'h0;
		{fwd_valid, barrier_valid, walk_valid, dvm_valid} = 4'h0;
		{h_walk_valid, h_dvm_valid, h_div_byp} = 3'h0;
		fwd_id = 4'h0;
		fwd_tag = 15'h0000;
		walk_queue = 3'h0;
		fail_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_widths();
		t_ids();
		t_stall();
		t_prio();
		t_clocks();
		t_half();
		close_out();
	end
endmodule

/* File: bench/axi_sink_model.sv */
// downstream slave model that accepts output beats, with bench-controlled back pressure
`timescale 1ns/10ps
module axi_sink_model #(
	parameter int ID_W = 5
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic valid,
	input wire logic [ID_W-1:0] id,
	input wire logic stall,
	output logic ready,
	output logic [ID_W-1:0] last_id,
	output int beats
);
	////////////////////////////////////////////////////////////////////////////////
	// ready follows stall alone, so a standing beat can be held for any length
	assign ready = !stall;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			beats <= 0;
			last_id <= '0;
		end else if (valid && ready) begin
			beats <= beats + 1;
			last_id <= id;
		end
	end
endmodule

/* File: design/axi_output_id_mapper.sv */
// output axi id generation for the buffer unit and control unit ports
`timescale 1ns/10ps
module axi_output_id_mapper #(
	parameter int WALK_QUEUES = id_map_pkg::WALK_QUEUES_DEF,
	parameter int BUFFER_IN_ID_BITS = id_map_pkg::BUF_IN_ID_DEF,
	parameter int TAG_BITS = id_map_pkg::TAG_BITS_DEF,
	parameter bit SHARED_PORT = 1'b1,
	parameter bit HALF_CLOCK = 1'b0,
	// widths below are derived once at elaboration
	localparam int WB = id_map_pkg::walk_id_bits(WALK_QUEUES),
	localparam int WQ_W = (WB < 1) ? 1 : WB,
	localparam int MAIN_OUT = id_map_pkg::main_out_bits(BUFFER_IN_ID_BITS, WB, SHARED_PORT),
	localparam int CTL_OUT = id_map_pkg::ctl_out_bits(WB)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fwd_valid,
	input wire logic [BUFFER_IN_ID_BITS-1:0] fwd_id,
	input wire logic [TAG_BITS-1:0] fwd_tag,
	output logic fwd_ready,
	input wire logic barrier_valid,
	output logic barrier_ready,
	input wire logic walk_valid,
	input wire logic [WQ_W-1:0] walk_queue,
	output logic walk_ready,
	input wire logic dvm_valid,
	output logic dvm_ready,
	input wire logic test_gate_bypass,
	input wire logic test_div_bypass,
	output logic main_m_valid,
	output logic [MAIN_OUT-1:0] main_m_id,
	output logic [TAG_BITS-1:0] main_m_tag,
	input wire logic main_m_ready,
	output logic ctl_m_valid,
	output logic [CTL_OUT-1:0] ctl_m_id,
	input wire logic ctl_m_ready,
	output logic core_tick,
	output logic clk_gate_open
);

	localparam logic [id_map_pkg::ID_MAX_BITS-1:0] QMASK =
		id_map_pkg::ID_MAX_BITS'((64'h1 << WB) - 64'h1);

	id_map_pkg::beat_s t_beat_reg;
	id_map_pkg::beat_s t_beat_next;
	id_map_pkg::beat_s c_beat_reg;
	id_map_pkg::beat_s c_beat_next;
	logic t_valid_reg;
	logic t_valid_next;
	logic c_valid_reg;
	logic c_valid_next;
	logic [MAIN_OUT-1:0] t_id_w;
	logic [CTL_OUT-1:0] c_id_w;

	////////////////////////////////////////////////////////////////////////
	// control unit requests only advance on core ticks
	wire logic cu_dvm = dvm_valid && core_tick;
	wire logic cu_walk = walk_valid && core_tick && !cu_dvm;

	// buffer unit port: dvm, walk, barrier, forwarded in falling priority
	wire logic t_load = !t_valid_reg || main_m_ready;
	wire logic t_dvm = SHARED_PORT && cu_dvm;
	wire logic t_walk = SHARED_PORT && cu_walk;
	wire logic t_bar = barrier_valid && !t_dvm && !t_walk;
	wire logic t_fwd = fwd_valid && !t_dvm && !t_walk && !barrier_valid;
	wire logic t_take = t_load && (t_dvm || t_walk || t_bar || t_fwd);
	wire id_map_pkg::src_e t_src = t_dvm ? id_map_pkg::SRC_DVM :
		t_walk ? id_map_pkg::SRC_WALK :
		t_bar ? id_map_pkg::SRC_SYNC : id_map_pkg::SRC_FWD;

	// control unit port, idle when it shares unit zero's port
	wire logic c_load = !c_valid_reg || ctl_m_ready;
	wire logic c_dvm = !SHARED_PORT && cu_dvm;
	wire logic c_walk = !SHARED_PORT && cu_walk;
	wire logic c_take = c_load && (c_dvm || c_walk);
	wire id_map_pkg::src_e c_src = c_dvm ? id_map_pkg::SRC_DVM : id_map_pkg::SRC_WALK;

	assign fwd_ready = t_load && t_fwd;
	assign barrier_ready = t_load && t_bar;
	assign walk_ready = SHARED_PORT ? (t_load && t_walk) : (c_load && c_walk);
	assign dvm_ready = SHARED_PORT ? (t_load && t_dvm) : (c_load && c_dvm);

	////////////////////////////////////////////////////////////////////////
	id_encoder #(
		.IN_W(BUFFER_IN_ID_BITS),
		.OUT_W(MAIN_OUT),
		.WB(WB),
		.WQ_W(WQ_W),
		.MUXED(SHARED_PORT)
	) u_main_enc (
		.src(t_src),
		.in_id(fwd_id),
		.queue(walk_queue),
		.id(t_id_w)
	);

	id_encoder #(
		.IN_W(1),
		.OUT_W(CTL_OUT),
		.WB(WB),
		.WQ_W(WQ_W),
		.MUXED(1'b0)
	) u_ctl_enc (
		.src(c_src),
		.in_id(1'b0),
		.queue(walk_queue),
		.id(c_id_w)
	);

	// activity that keeps the control core clock gate open
	wire logic core_active = walk_valid || dvm_valid || c_valid_reg ||
		(SHARED_PORT && t_valid_reg && t_beat_reg.src[1]);

	core_clock_ctl #(
		.HALF_CLOCK(HALF_CLOCK)
	) u_clk_ctl (
		.clk(clk),
		.rst_n(rst_n),
		.test_gate_bypass(test_gate_bypass),
		.test_div_bypass(test_div_bypass),
		.core_active(core_active),
		.core_tick(core_tick),
		.gate_open(clk_gate_open)
	);

	////////////////////////////////////////////////////////////////////////
	// tag only travels with forwarded traffic; generated beats carry zero
	assign t_beat_next = t_take ? id_map_pkg::beat_s'{
		id: id_map_pkg::ID_MAX_BITS'(t_id_w),
		tag: t_fwd ? id_map_pkg::TAG_MAX_BITS'(fwd_tag) : '0,
		src: t_src} : t_beat_reg;
	assign t_valid_next = t_take || (t_valid_reg && !main_m_ready);
	assign c_beat_next = c_take ? id_map_pkg::beat_s'{
		id: id_map_pkg::ID_MAX_BITS'(c_id_w),
		tag: '0,
		src: c_src} : c_beat_reg;
	assign c_valid_next = c_take || (c_valid_reg && !ctl_m_ready);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			t_beat_reg <= id_map_pkg::BEAT_RST;
			t_valid_reg <= id_map_pkg::VALID_RST;
			c_beat_reg <= id_map_pkg::BEAT_RST;
			c_valid_reg <= id_map_pkg::VALID_RST;
		end else begin
			t_beat_reg <= t_beat_next;
			t_valid_reg <= t_valid_next;
			c_beat_reg <= c_beat_next;
			c_valid_reg <= c_valid_next;
		end
	end

	assign main_m_valid = t_valid_reg;
	assign main_m_id = t_beat_reg.id[MAIN_OUT-1:0];
	assign main_m_tag = t_beat_reg.tag[TAG_BITS-1:0];
	assign ctl_m_valid = c_valid_reg;
	assign ctl_m_id = c_beat_reg.id[CTL_OUT-1:0];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_FWD_PAD: assert property (
		fwd_valid && fwd_ready |=> main_m_valid && main_m_id == MAIN_OUT'($past(fwd_id)))
		else $error("forwarded id not zero padded copy");
	AST_FWD_TAG: assert property (
		fwd_valid && fwd_ready |=> main_m_tag == $past(fwd_tag))
		else $error("context tag not carried with forwarded beat");
	AST_BARRIER_ONES: assert property (
		barrier_valid && barrier_ready |=> main_m_valid && (&main_m_id))
		else $error("barrier id not all ones");
	AST_BARRIER_TAG: assert property (
		barrier_valid && barrier_ready |=> main_m_tag == '0)
		else $error("generated barrier beat carries a tag");
	AST_WALK_MARK: assert property (
		SHARED_PORT && walk_ready |=> main_m_valid &&
		(main_m_id >> WB) == (MAIN_OUT'(id_map_pkg::WALK_MARK) << (MAIN_OUT - 2 - WB)))
		else $error("walk id top pattern wrong");
	AST_WALK_QUEUE: assert property (
		walk_valid && walk_ready |=>
		((SHARED_PORT ? id_map_pkg::ID_MAX_BITS'(main_m_id) : id_map_pkg::ID_MAX_BITS'(ctl_m_id))
		& QMASK) == (id_map_pkg::ID_MAX_BITS'($past(walk_queue)) & QMASK))
		else $error("walk queue number not in low bits");
	AST_DVM_MARK: assert property (
		SHARED_PORT && dvm_ready |=> main_m_valid &&
		main_m_id == (MAIN_OUT'(id_map_pkg::DVM_MARK) << (MAIN_OUT - 3)))
		else $error("dvm complete id pattern wrong");
	AST_CTL_MSB: assert property (
		!SHARED_PORT && (walk_ready || dvm_ready) |=>
		ctl_m_valid && ctl_m_id[CTL_OUT-1] == $past(dvm_ready))
		else $error("control unit id top bit does not mark dvm");
	AST_DVM_FIRST: assert property (
		dvm_valid && walk_valid |-> !walk_ready)
		else $error("walk accepted over a pending dvm complete");
	AST_SHARED_IDLE: assert property (
		SHARED_PORT |-> !ctl_m_valid)
		else $error("separate port active while shared");
	AST_MAIN_HOLD: assert property (
		main_m_valid && !main_m_ready |=> main_m_valid && $stable(main_m_id) && $stable(main_m_tag))
		else $error("buffer port beat changed while stalled");
	AST_CTL_HOLD: assert property (
		ctl_m_valid && !ctl_m_ready |=> ctl_m_valid && $stable(ctl_m_id))
		else $error("control port beat changed while stalled");
	// the bypass pin needs three edges to clear its synchroniser
	AST_HALF_WALK: assert property (
		(!test_div_bypass) [*3] ##0 (HALF_CLOCK && walk_ready) |=> !walk_ready)
		else $error("walk accepted on consecutive edges in half clock");
	AST_OFF_TICK: assert property (
		!core_tick |-> !walk_ready && !dvm_ready)
		else $error("control request accepted between core ticks");

	COV_FWD_B2B: cover property (fwd_ready ##1 fwd_ready);
	COV_WALK: cover property (walk_ready ##1 (main_m_valid || ctl_m_valid));
	COV_DVM: cover property (dvm_ready);
	COV_STALL: cover property (main_m_valid && !main_m_ready ##1 main_m_ready);

endmodule

/* File: design/core_clock_ctl.sv */
// half-rate core tick, divider bypass and clock gate bypass for the control unit
`timescale 1ns/10ps
module core_clock_ctl #(
	parameter bit HALF_CLOCK = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic test_gate_bypass,
	input wire logic test_div_bypass,
	input wire logic core_active,
	output logic core_tick,
	output logic gate_open
);

	logic [1:0] gate_sync_reg;
	logic [1:0] div_sync_reg;
	logic phase_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_sync_reg <= id_map_pkg::SYNC_RST;
			div_sync_reg <= id_map_pkg::SYNC_RST;
			phase_reg <= id_map_pkg::PHASE_RST;
		end else begin
			gate_sync_reg <= {gate_sync_reg[0], test_gate_bypass};
			div_sync_reg <= {div_sync_reg[0], test_div_bypass};
			phase_reg <= ~phase_reg;
		end
	end

	// divider realised as an every-other-edge tick; bypass gives full rate
	assign core_tick = !HALF_CLOCK || div_sync_reg[1] || phase_reg;
	assign gate_open = core_active || gate_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_HALF_RATE: assert property (
		(HALF_CLOCK && !div_sync_reg[1] && core_tick) ##1 !div_sync_reg[1] |-> !core_tick)
		else $error("core tick not at half rate");
	AST_DIV_BYPASS: assert property (
		test_div_bypass [*3] |-> core_tick)
		else $error("divider bypass did not force full rate");
	AST_GATE_BYPASS: assert property (
		test_gate_bypass [*3] |-> gate_open)
		else $error("gate bypass did not open clock gate");
	AST_GATE_IDLE: assert property (
		(!test_gate_bypass) [*3] ##0 !core_active |-> !gate_open)
		else $error("clock gate open while idle");
	COV_HALF_TICK: cover property (HALF_CLOCK && core_tick ##1 !core_tick);

endmodule

/* File: design/id_encoder.sv */
// combinational id pattern builder for one output port
`timescale 1ns/10ps
module id_encoder #(
	parameter int IN_W = 4,
	parameter int OUT_W = 5,
	parameter int WB = 3,
	parameter int WQ_W = 3,
	parameter bit MUXED = 1'b0
) (
	input wire id_map_pkg::src_e src,
	input wire logic [IN_W-1:0] in_id,
	input wire logic [WQ_W-1:0] queue,
	output logic [OUT_W-1:0] id
);

	localparam int WSH = OUT_W - 2;
	localparam int DSH = (OUT_W >= 3) ? OUT_W - 3 : 0;

	wire logic [OUT_W-1:0] fwd_w = OUT_W'(in_id);
	wire logic [OUT_W-1:0] sync_w = '1;
	// a single queue needs no index bits, so the port value is dropped
	wire logic [OUT_W-1:0] qid_w = (WB == 0) ? '0 : OUT_W'(queue);
	wire logic [OUT_W-1:0] walk_mux_w = (OUT_W'(id_map_pkg::WALK_MARK) << WSH) | qid_w;
	wire logic [OUT_W-1:0] dvm_mux_w = OUT_W'(id_map_pkg::DVM_MARK) << DSH;
	wire logic [OUT_W-1:0] dvm_sep_w = OUT_W'(1'b1) << (OUT_W - 1);
	wire logic [OUT_W-1:0] walk_w = MUXED ? walk_mux_w : qid_w;
	wire logic [OUT_W-1:0] dvm_w = MUXED ? dvm_mux_w : dvm_sep_w;

	assign id = (src == id_map_pkg::SRC_FWD) ? fwd_w :
		(src == id_map_pkg::SRC_SYNC) ? sync_w :
		(src == id_map_pkg::SRC_WALK) ? walk_w : dvm_w;

endmodule

/* File: design/id_map_pkg.sv */
// shared constants, carrier types and width helpers for the output id mapper
package id_map_pkg;

	localparam int WALK_QUEUES_DEF = 8;
	localparam int BUF_IN_ID_DEF = 4;
	localparam int TAG_BITS_DEF = 15;
	localparam int ID_MAX_BITS = 32;
	localparam int TAG_MAX_BITS = 16;

	localparam logic VALID_RST = 1'h0;
	localparam logic PHASE_RST = 1'h0;
	localparam logic [1:0] SYNC_RST = 2'h0;

	// marker patterns placed at the top of the shared-port id
	localparam logic [1:0] WALK_MARK = 2'h2;
	localparam logic [2:0] DVM_MARK = 3'h6;

	typedef enum logic [1:0] {
		SRC_FWD = 2'h0,
		SRC_SYNC = 2'h1,
		SRC_WALK = 2'h2,
		SRC_DVM = 2'h3
	} src_e;

	typedef struct packed {
		logic [ID_MAX_BITS-1:0] id;
		logic [TAG_MAX_BITS-1:0] tag;
		src_e src;
	} beat_s;

	localparam beat_s BEAT_RST = '{id: '0, tag: '0, src: SRC_FWD};

	// power-of-two rounding falls out of the ceiling log
	function automatic int walk_id_bits(input int queues);
		return $clog2(queues);
	endfunction

	function automatic int ctl_out_bits(input int wb);
		return wb + 1;
	endfunction

	function automatic int shared_out_bits(input int in_bits, input int wb);
		return (in_bits > wb) ? in_bits + 1 : wb + 2;
	endfunction

	function automatic int main_out_bits(input int in_bits, input int wb, input bit muxed);
		return muxed ? shared_out_bits(in_bits, wb) : in_bits + 1;
	endfunction

endpackage
